// ==== rtl/orf_pkg.sv ====
// Shared constants for the operation result flag unit
package orf_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int WORD_W = 16;
	localparam int OUT_W  = 16;
	localparam int FP_W   = 6;
	localparam int BASES  = 8;
	localparam int BASE_W = 3;
	localparam int SLOT_W = 4;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PUT    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_GET    = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_FP     = 8'h10;

	// Per-base word banks: address bits [7:5] pick the bank, [4:2] the base
	localparam int BANK_MSB = 7;
	localparam int BANK_LSB = 5;
	localparam int IDX_MSB  = 4;
	localparam int IDX_LSB  = 2;
	localparam logic [2:0] BANK_ERR  = 3'h2;
	localparam logic [2:0] BANK_DONE = 3'h3;
	localparam logic [1:0] ALIGN_OK  = 2'h0;

	// Status register bits
	localparam int ST_OP_ERR  = 0;
	localparam int ST_OP_LAT  = 1;
	localparam int ST_ARY     = 2;
	localparam int ST_ARY_LAT = 3;
	localparam int ST_ALL_OFF = 4;

	// Floating point flag bits; latched copies of bits 1-5 sit at FP_LAT_LSB + bit - 1
	localparam int FP_E       = 0;
	localparam int FP_I       = 1;
	localparam int FP_Z       = 5;
	localparam int FP_LAT_LSB = 8;
	localparam int FP_LAT_W   = 5;

	// Reset and step values
	localparam logic [DATA_W-1:0] ZERO_WORD  = 32'h0000_0000;
	localparam logic [DATA_W-1:0] COUNT_STEP = 32'h0000_0001;
	localparam logic [WORD_W-1:0] ZERO_HALF  = 16'h0000;
	localparam logic [FP_W-1:0]   ZERO_FP    = 6'h00;
	localparam logic [OUT_W-1:0]  ALL_OFF    = 16'h0000;
endpackage : orf_pkg

// ==== rtl/orf_bus_if.sv ====
// Internal carrier between the bus front end and the flag registers
interface orf_bus_if;
	logic [orf_pkg::ADDR_W-1:0] addr;
	logic [orf_pkg::DATA_W-1:0] wdata;
	logic                       wr_en;
	logic [orf_pkg::DATA_W-1:0] rdata;
	logic                       rd_err;

	modport front (output addr, output wdata, output wr_en,
		input rdata, input rd_err);
	modport regs (input addr, input wdata, input wr_en,
		output rdata, output rd_err);
endinterface : orf_bus_if

// ==== rtl/orf_apb_slave.sv ====
// APB front end: setup-cycle read capture and access-phase write strobe
module orf_apb_slave (
	input  wire logic                       clk_in,
	input  wire logic                       rst_b_in,
	input  wire logic                       ce_in,
	input  wire logic                       psel_in,
	input  wire logic                       penable_in,
	input  wire logic                       pwrite_in,
	input  wire logic [orf_pkg::ADDR_W-1:0] paddr_in,
	input  wire logic [orf_pkg::DATA_W-1:0] pwdata_in,
	output logic      [orf_pkg::DATA_W-1:0] prdata_out,
	output logic                            pready_out,
	output logic                            pslverr_out,
	orf_bus_if.front                        bus
);
	logic err_q;

	// Zero wait states; frozen clock enable stalls the access phase
	assign pready_out  = psel_in & penable_in & ce_in;
	assign pslverr_out = pready_out & err_q;
	assign bus.addr    = paddr_in;
	assign bus.wdata   = pwdata_in;
	assign bus.wr_en   = pready_out & pwrite_in;

	// Read data is caught in the setup cycle so PRDATA comes from a flop
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			prdata_out <= orf_pkg::ZERO_WORD;
			err_q      <= 1'b0;
		end
		else if (ce_in && psel_in && !penable_in)
		begin
			prdata_out <= pwrite_in ? orf_pkg::ZERO_WORD : bus.rdata;
			err_q      <= bus.rd_err;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	chk_apb_zero_wait: assert property (
		psel_in && !penable_in && ce_in ##1 penable_in && ce_in
		|-> pready_out)
		else $error("access phase not answered at once");
	cov_apb_write: cover property (bus.wr_en);
endmodule : orf_apb_slave

// ==== rtl/orf_top.sv ====
// Operation result flags, floating point flags, service counters, APB regs
// Overview of operation
// [RULE_01] Operation error flag renewed every function execution
// [RULE_02] Latch error during program block until end
// [RULE_03] Software clears latched operation error by writing
// [RULE_04] Array flag on index beyond array size
// [RULE_05] Array index latch persists after offending access
// [RULE_06] All-off high only when every output off
// [RULE_07] 32-bit put counter counts each put service
// [RULE_08] 32-bit get counter counts each get service
// [RULE_09] Irregular floating input flag, no latch copy
// [RULE_10] Inexact result sets flag and latch
// [RULE_11] Overflow sets flag and latch
// [RULE_12] Underflow sets flag and latch
// [RULE_13] Invalid operation sets flag and latch
// [RULE_14] Zero divisor sets flag and latch
// [RULE_15] Error and completion word per base 0-7
// [RULE_16] Floating flags renewed; latches held until cleared
//
// Chosen here: register access over APB and the register addresses.
module orf_top (
	input  wire logic                       CLK_SYS_IN,
	input  wire logic                       RST_B_IN,
	input  wire logic                       CE_IN,
	input  wire logic                       PSEL_IN,
	input  wire logic                       PENABLE_IN,
	input  wire logic                       PWRITE_IN,
	input  wire logic [orf_pkg::ADDR_W-1:0] PADDR_IN,
	input  wire logic [orf_pkg::DATA_W-1:0] PWDATA_IN,
	output logic      [orf_pkg::DATA_W-1:0] PRDATA_OUT,
	output logic                            PREADY_OUT,
	output logic                            PSLVERR_OUT,
	input  wire logic                       OP_EXEC_IN,
	input  wire logic                       OP_ERR_IN,
	input  wire logic [orf_pkg::WORD_W-1:0] LOGIC_RESULT_IN,
	input  wire logic                       PB_RUN_IN,
	input  wire logic                       ARY_ACCESS_IN,
	input  wire logic [orf_pkg::WORD_W-1:0] ARY_INDEX_IN,
	input  wire logic [orf_pkg::WORD_W-1:0] ARY_SIZE_IN,
	input  wire logic [orf_pkg::OUT_W-1:0]  OUTPUTS_STATE_IN,
	input  wire logic                       PUT_EXEC_IN,
	input  wire logic                       GET_EXEC_IN,
	input  wire logic                       FP_OP_IN,
	input  wire logic [orf_pkg::FP_W-1:0]   FP_EXC_IN,
	input  wire logic                       XFER_START_IN,
	input  wire logic                       XFER_DONE_IN,
	input  wire logic                       XFER_ERR_IN,
	input  wire logic [orf_pkg::BASE_W-1:0] XFER_BASE_IN,
	input  wire logic [orf_pkg::SLOT_W-1:0] XFER_SLOT_IN,
	output logic                            OUTPUTS_ALL_OFF_OUT,
	output logic                            OP_ERROR_LATCH_OUT
);
	logic                       op_error_flag;
	logic                       op_error_latch;
	logic [orf_pkg::WORD_W-1:0] logic_result_word;
	logic                       array_range_flag;
	logic                       array_range_latch;
	logic                       outputs_all_off;
	logic [orf_pkg::DATA_W-1:0] put_service_count;
	logic [orf_pkg::DATA_W-1:0] get_service_count;
	logic [orf_pkg::FP_W-1:0]   fp_flags;
	logic [orf_pkg::FP_LAT_W-1:0] fp_latch;
	logic [orf_pkg::WORD_W-1:0] remote_xfer_error_word [orf_pkg::BASES];
	logic [orf_pkg::WORD_W-1:0] remote_xfer_done_word  [orf_pkg::BASES];
	logic                       pb_run_q;
	logic                       pb_end;
	logic                       op_latch_set;
	logic                       op_latch_clr;
	logic                       range_hit;
	logic                       fp_wr;
	logic [orf_pkg::FP_LAT_W-1:0] fp_lat_set;
	logic [orf_pkg::FP_LAT_W-1:0] fp_lat_clr;
	logic [orf_pkg::WORD_W-1:0] slot_mask;

	orf_bus_if bus ();

	orf_apb_slave u_apb (
		.clk_in      (CLK_SYS_IN),
		.rst_b_in    (RST_B_IN),
		.ce_in       (CE_IN),
		.psel_in     (PSEL_IN),
		.penable_in  (PENABLE_IN),
		.pwrite_in   (PWRITE_IN),
		.paddr_in    (PADDR_IN),
		.pwdata_in   (PWDATA_IN),
		.prdata_out  (PRDATA_OUT),
		.pready_out  (PREADY_OUT),
		.pslverr_out (PSLVERR_OUT),
		.bus         (bus.front)
	);

	// Width of the base index inside the per-base banks
	localparam int BASE_IDX_W = orf_pkg::BASE_W;

	// Word-aligned write hit on a given register
	function automatic logic wr_hit(input logic [orf_pkg::ADDR_W-1:0] a,
		input logic en, input logic [orf_pkg::ADDR_W-1:0] ofs);
		wr_hit = en && (a == ofs);
	endfunction : wr_hit

	// Read mux; returns {error, data}, unmapped or unaligned gives error
	function automatic logic [orf_pkg::DATA_W:0] rd_word(
		input logic [orf_pkg::ADDR_W-1:0] a);
		logic [orf_pkg::DATA_W-1:0] d;
		logic                       e;
		logic [BASE_IDX_W-1:0]      i;
		d = orf_pkg::ZERO_WORD;
		e = 1'b0;
		i = a[orf_pkg::IDX_MSB:orf_pkg::IDX_LSB];
		if (a[1:0] != orf_pkg::ALIGN_OK)
			e = 1'b1;
		else if (a == orf_pkg::OFS_STATUS)
		begin
			d[orf_pkg::ST_OP_ERR]  = op_error_flag;
			d[orf_pkg::ST_OP_LAT]  = op_error_latch;
			d[orf_pkg::ST_ARY]     = array_range_flag;
			d[orf_pkg::ST_ARY_LAT] = array_range_latch;
			d[orf_pkg::ST_ALL_OFF] = outputs_all_off;
		end
		else if (a == orf_pkg::OFS_RESULT)
			d[orf_pkg::WORD_W-1:0] = logic_result_word;
		else if (a == orf_pkg::OFS_PUT)
			d = put_service_count;
		else if (a == orf_pkg::OFS_GET)
			d = get_service_count;
		else if (a == orf_pkg::OFS_FP)
		begin
			d[orf_pkg::FP_W-1:0] = fp_flags;
			d[orf_pkg::FP_LAT_LSB +: orf_pkg::FP_LAT_W] = fp_latch;
		end
		else if (a[orf_pkg::BANK_MSB:orf_pkg::BANK_LSB] == orf_pkg::BANK_ERR)
			d[orf_pkg::WORD_W-1:0] = remote_xfer_error_word[i];
		else if (a[orf_pkg::BANK_MSB:orf_pkg::BANK_LSB] == orf_pkg::BANK_DONE)
			d[orf_pkg::WORD_W-1:0] = remote_xfer_done_word[i];
		else
			e = 1'b1;
		rd_word = {e, d};
	endfunction : rd_word

	// Read path back to the bus front end; a process rather than an assign
	// so a change of any register, not only of the address, re-runs it
	always_comb
	begin
		{bus.rd_err, bus.rdata} = rd_word(bus.addr);
	end

	// Event decode shared by the flag processes
	assign pb_end       = pb_run_q & ~PB_RUN_IN;
	assign op_latch_set = OP_EXEC_IN & OP_ERR_IN & PB_RUN_IN;
	assign op_latch_clr = pb_end | (wr_hit(bus.addr, bus.wr_en,
		orf_pkg::OFS_STATUS) & bus.wdata[orf_pkg::ST_OP_LAT]);
	assign range_hit    = ARY_INDEX_IN >= ARY_SIZE_IN;
	assign fp_wr        = wr_hit(bus.addr, bus.wr_en, orf_pkg::OFS_FP);
	assign fp_lat_set   = FP_OP_IN ? FP_EXC_IN[orf_pkg::FP_Z:orf_pkg::FP_I]
		: {orf_pkg::FP_LAT_W{1'b0}};
	assign fp_lat_clr   = fp_wr ?
		bus.wdata[orf_pkg::FP_LAT_LSB +: orf_pkg::FP_LAT_W]
		: {orf_pkg::FP_LAT_W{1'b0}};
	assign slot_mask    = orf_pkg::WORD_W'(1) << XFER_SLOT_IN;

	// Per-operation error and logic result follow each function call
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_B_IN)
		begin
			op_error_flag     <= 1'b0;
			logic_result_word <= orf_pkg::ZERO_HALF;
		end
		else if (CE_IN && OP_EXEC_IN)
		begin
			op_error_flag     <= OP_ERR_IN; // RULE_01
			logic_result_word <= LOGIC_RESULT_IN;
		end
	end

	// Program block latch; a new error beats a clear in the same cycle
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_B_IN)
		begin
			op_error_latch <= 1'b0;
			pb_run_q       <= 1'b0;
		end
		else if (CE_IN)
		begin
			pb_run_q       <= PB_RUN_IN;
			op_error_latch <= op_latch_set // RULE_02
				| (op_error_latch & ~op_latch_clr); // RULE_03
		end
	end

	// Array range check; the latch has no clear but reset
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_B_IN)
		begin
			array_range_flag  <= 1'b0;
			array_range_latch <= 1'b0;
		end
		else if (CE_IN && ARY_ACCESS_IN)
		begin
			array_range_flag  <= range_hit; // RULE_04
			array_range_latch <= array_range_latch | range_hit; // RULE_05
		end
	end

	// Registered so a glitchy output vector never shows a false all-off
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_B_IN)
			outputs_all_off <= 1'b0;
		else if (CE_IN)
			outputs_all_off <= OUTPUTS_STATE_IN == orf_pkg::ALL_OFF; // RULE_06
	end

	// Service counters wrap silently at the top of their range
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_B_IN)
		begin
			put_service_count <= orf_pkg::ZERO_WORD;
			get_service_count <= orf_pkg::ZERO_WORD;
		end
		else if (CE_IN)
		begin
			if (PUT_EXEC_IN)
				put_service_count <= put_service_count
					+ orf_pkg::COUNT_STEP; // RULE_07
			if (GET_EXEC_IN)
				get_service_count <= get_service_count
					+ orf_pkg::COUNT_STEP; // RULE_08
		end
	end

	// Floating point flags renewed per operation, latches are sticky
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_B_IN)
		begin
			fp_flags <= orf_pkg::ZERO_FP;
			fp_latch <= {orf_pkg::FP_LAT_W{1'b0}};
		end
		else if (CE_IN)
		begin
			if (FP_OP_IN)
				fp_flags <= FP_EXC_IN; // RULE_09 RULE_16
			// RULE_10 RULE_11 RULE_12 RULE_13 RULE_14
			fp_latch <= fp_lat_set | (fp_latch & ~fp_lat_clr); // RULE_16
		end
	end

	// Per-base words; start clears done, completion records the outcome
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_B_IN)
		begin
			for (int b = 0; b < orf_pkg::BASES; b++)
			begin
				remote_xfer_error_word[b] <= orf_pkg::ZERO_HALF;
				remote_xfer_done_word[b]  <= orf_pkg::ZERO_HALF;
			end
		end
		else if (CE_IN && XFER_DONE_IN)
		begin
			remote_xfer_done_word[XFER_BASE_IN] <= // RULE_15
				remote_xfer_done_word[XFER_BASE_IN] | slot_mask;
			remote_xfer_error_word[XFER_BASE_IN] <= XFER_ERR_IN
				? remote_xfer_error_word[XFER_BASE_IN] | slot_mask
				: remote_xfer_error_word[XFER_BASE_IN] & ~slot_mask;
		end
		else if (CE_IN && XFER_START_IN)
			remote_xfer_done_word[XFER_BASE_IN] <=
				remote_xfer_done_word[XFER_BASE_IN] & ~slot_mask;
	end

	// Pin views of two status bits
	assign OUTPUTS_ALL_OFF_OUT = outputs_all_off;
	assign OP_ERROR_LATCH_OUT  = op_error_latch;

	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_B_IN);

	chk_op_error_refresh: assert property ( // RULE_01
		CE_IN && OP_EXEC_IN |=> op_error_flag == $past(OP_ERR_IN))
		else $error("operation error flag not renewed");
	chk_op_latch_set: assert property ( // RULE_02
		CE_IN && op_latch_set |=> op_error_latch)
		else $error("operation error latch not set");
	chk_op_latch_clear: assert property ( // RULE_03
		CE_IN && op_latch_clr && !op_latch_set |=> !op_error_latch)
		else $error("operation error latch not cleared");
	chk_array_flag: assert property ( // RULE_04
		CE_IN && ARY_ACCESS_IN
		|=> array_range_flag == ($past(ARY_INDEX_IN) >= $past(ARY_SIZE_IN)))
		else $error("array range flag wrong");
	chk_array_latch: assert property ( // RULE_05
		array_range_latch |=> array_range_latch)
		else $error("array range latch dropped");
	chk_all_off_state: assert property ( // RULE_06
		CE_IN && RST_B_IN |=> outputs_all_off
		== ($past(OUTPUTS_STATE_IN) == orf_pkg::ALL_OFF))
		else $error("all-off indicator wrong");
	chk_put_count: assert property ( // RULE_07
		CE_IN && PUT_EXEC_IN
		|=> put_service_count == $past(put_service_count) + 1)
		else $error("put counter did not step");
	chk_get_count: assert property ( // RULE_08
		CE_IN && GET_EXEC_IN
		|=> get_service_count == $past(get_service_count) + 1)
		else $error("get counter did not step");
	chk_fp_irregular: assert property ( // RULE_09
		CE_IN && FP_OP_IN |=> fp_flags[orf_pkg::FP_E]
		== $past(FP_EXC_IN[orf_pkg::FP_E]))
		else $error("irregular input flag wrong");
	chk_fp_latch_set: assert property ( // RULE_10 RULE_11 RULE_12 RULE_13 RULE_14
		CE_IN |=> (fp_latch & $past(fp_lat_set)) == $past(fp_lat_set))
		else $error("floating point latch not set");
	chk_fp_latch_hold: assert property ( // RULE_16
		CE_IN && !fp_wr |=> (~fp_latch & $past(fp_latch)) == 0)
		else $error("floating point latch lost without clear");
	chk_xfer_done: assert property ( // RULE_15
		CE_IN && XFER_DONE_IN |=> remote_xfer_done_word[$past(XFER_BASE_IN)]
		[$past(XFER_SLOT_IN)])
		else $error("completion bit not recorded");
	chk_op_latch_hold: assert property ( // RULE_02
		CE_IN && op_error_latch && !op_latch_clr |=> op_error_latch)
		else $error("operation error latch dropped early");
	chk_array_latch_set: assert property ( // RULE_05
		CE_IN && ARY_ACCESS_IN && range_hit |=> array_range_latch)
		else $error("array range latch not set");
	chk_fp_flag_refresh: assert property ( // RULE_16
		CE_IN && FP_OP_IN |=> fp_flags == $past(FP_EXC_IN))
		else $error("floating point flags not renewed");
	chk_fp_latch_clear: assert property ( // RULE_16
		CE_IN && fp_wr
		|=> (fp_latch & $past(fp_lat_clr) & ~$past(fp_lat_set)) == 0)
		else $error("floating point latch not cleared");
	chk_xfer_error: assert property ( // RULE_15
		CE_IN && XFER_DONE_IN
		|=> remote_xfer_error_word[$past(XFER_BASE_IN)][$past(XFER_SLOT_IN)]
		== $past(XFER_ERR_IN))
		else $error("error bit not recorded");

	cov_pb_latch_end: cover property (op_error_latch ##1 pb_end);
	cov_array_over: cover property (CE_IN && ARY_ACCESS_IN && range_hit);
	cov_fp_div_zero: cover property (fp_latch[orf_pkg::FP_LAT_W-1]);
	cov_put_and_get: cover property (PUT_EXEC_IN && GET_EXEC_IN);
endmodule : orf_top

// ==== bench/tb.sv ====
// Self-checking bench for the operation result flag unit
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                       clk;
	logic                       rst_b;
	logic                       ce;
	logic                       psel;
	logic                       penable;
	logic                       pwrite;
	logic [orf_pkg::ADDR_W-1:0] paddr;
	logic [orf_pkg::DATA_W-1:0] pwdata;
	logic [orf_pkg::DATA_W-1:0] prdata;
	logic                       pready;
	logic                       pslverr;
	logic                       op_exec;
	logic                       op_err;
	logic [orf_pkg::WORD_W-1:0] result;
	logic                       pb_run;
	logic                       ary_acc;
	logic [orf_pkg::WORD_W-1:0] ary_idx;
	logic [orf_pkg::WORD_W-1:0] ary_size;
	logic [orf_pkg::OUT_W-1:0]  outs;
	logic                       put_ex;
	logic                       get_ex;
	logic                       fp_op;
	logic [orf_pkg::FP_W-1:0]   fp_exc;
	logic                       x_start;
	logic                       x_done;
	logic                       x_err;
	logic [orf_pkg::BASE_W-1:0] x_base;
	logic [orf_pkg::SLOT_W-1:0] x_slot;
	logic                       all_off;
	logic                       lat_out;
	logic [31:0]                lat;
	int                         n_mismatch;
	int                         comparisons;

	// Free-running system clock, 50 MHz
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	orf_top u_dut (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce),
		.PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .OP_EXEC_IN(op_exec),
		.OP_ERR_IN(op_err), .LOGIC_RESULT_IN(result), .PB_RUN_IN(pb_run),
		.ARY_ACCESS_IN(ary_acc), .ARY_INDEX_IN(ary_idx),
		.ARY_SIZE_IN(ary_size), .OUTPUTS_STATE_IN(outs),
		.PUT_EXEC_IN(put_ex), .GET_EXEC_IN(get_ex), .FP_OP_IN(fp_op),
		.FP_EXC_IN(fp_exc), .XFER_START_IN(x_start), .XFER_DONE_IN(x_done),
		.XFER_ERR_IN(x_err), .XFER_BASE_IN(x_base), .XFER_SLOT_IN(x_slot),
		.OUTPUTS_ALL_OFF_OUT(all_off), .OP_ERROR_LATCH_OUT(lat_out));

	task automatic summarize;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rdat, output logic er);
		int i;
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 16)
		begin
			n_mismatch++;
			summarize();
		end
		rdat = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic exp_err);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		check($sformatf("write err %h", a), {31'h0, e}, {31'h0, exp_err});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic exp_err);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		check($sformatf("read %h", a), r, exp);
		check($sformatf("read err %h", a), {31'h0, e}, {31'h0, exp_err});
	endtask : rd

	// Event pulses, one cycle wide
	task automatic op(input logic e, input logic [15:0] r);
		@(posedge clk);
		op_exec <= 1'b1;
		op_err  <= e;
		result  <= r;
		@(posedge clk);
		op_exec <= 1'b0;
	endtask : op

	task automatic ary(input logic [15:0] i, input logic [15:0] s);
		@(posedge clk);
		ary_acc  <= 1'b1;
		ary_idx  <= i;
		ary_size <= s;
		@(posedge clk);
		ary_acc <= 1'b0;
	endtask : ary

	task automatic fp(input logic [5:0] e);
		@(posedge clk);
		fp_op  <= 1'b1;
		fp_exc <= e;
		@(posedge clk);
		fp_op <= 1'b0;
	endtask : fp

	task automatic xfer(input logic d, input logic s, input logic e,
		input logic [2:0] b, input logic [3:0] sl);
		@(posedge clk);
		x_done  <= d;
		x_start <= s;
		x_err   <= e;
		x_base  <= b;
		x_slot  <= sl;
		@(posedge clk);
		x_done  <= 1'b0;
		x_start <= 1'b0;
	endtask : xfer

	// Main sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{op_exec, op_err, result, pb_run, ary_acc, ary_idx, ary_size} = '0;
		{outs, put_ex, get_ex, fp_op, fp_exc} = '0;
		{x_start, x_done, x_err, x_base, x_slot} = '0;
		n_mismatch = 0;
		comparisons = 0;
		ce = 1'b1;
		rst_b = 1'b0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		rd(orf_pkg::OFS_STATUS, 32'h0000_0010, 1'b0);
		rd(orf_pkg::OFS_PUT, 32'h0, 1'b0);
		rd(orf_pkg::OFS_FP, 32'h0, 1'b0);
		// Erring operation inside a running program block
		pb_run <= 1'b1;
		op(1'b1, 16'hA5C3);
		rd(orf_pkg::OFS_STATUS, 32'h0000_0013, 1'b0);
		rd(orf_pkg::OFS_RESULT, 32'h0000_A5C3, 1'b0);
		check("latch pin", {31'h0, lat_out}, 32'h1);
		op(1'b0, 16'h5A3C);
		rd(orf_pkg::OFS_STATUS, 32'h0000_0012, 1'b0);
		pb_run <= 1'b0;
		rd(orf_pkg::OFS_STATUS, 32'h0000_0010, 1'b0);
		pb_run <= 1'b1;
		op(1'b1, 16'h0001);
		wr(orf_pkg::OFS_STATUS, 32'h0000_0002, 1'b0);
		rd(orf_pkg::OFS_STATUS, 32'h0000_0011, 1'b0);
		pb_run <= 1'b0;
		// Index equal to the size is the first illegal one
		ary(16'h0008, 16'h0008);
		rd(orf_pkg::OFS_STATUS, 32'h0000_001D, 1'b0);
		ary(16'h0007, 16'h0008);
		rd(orf_pkg::OFS_STATUS, 32'h0000_0019, 1'b0);
		// A single output on clears the all-off indication
		outs <= 16'h8000;
		repeat (2) @(posedge clk);
		#1;
		check("all off pin", {31'h0, all_off}, 32'h0);
		rd(orf_pkg::OFS_STATUS, 32'h0000_0009, 1'b0);
		outs <= 16'h0000;
		repeat (2) @(posedge clk);
		#1;
		check("all off pin", {31'h0, all_off}, 32'h1);
		// Back-to-back service pulses; one pulse lost while frozen
		@(posedge clk);
		put_ex <= 1'b1;
		repeat (3) @(posedge clk);
		put_ex <= 1'b0;
		get_ex <= 1'b1;
		repeat (2) @(posedge clk);
		get_ex <= 1'b0;
		ce     <= 1'b0;
		put_ex <= 1'b1;
		@(posedge clk);
		put_ex <= 1'b0;
		ce     <= 1'b1;
		wr(orf_pkg::OFS_PUT, 32'hFFFF_FFFF, 1'b0);
		rd(orf_pkg::OFS_PUT, 32'h0000_0003, 1'b0);
		rd(orf_pkg::OFS_GET, 32'h0000_0002, 1'b0);
		// Each exception alone; latches accumulate, irregular has none
		lat = 32'h0;
		for (int b = 0; b < 6; b++)
		begin
			fp(6'h01 << b);
			if (b > 0)
				lat[7+b] = 1'b1;
			rd(orf_pkg::OFS_FP, lat | (32'h1 << b), 1'b0);
		end
		fp(6'h00);
		rd(orf_pkg::OFS_FP, 32'h0000_1F00, 1'b0);
		wr(orf_pkg::OFS_FP, 32'h0000_1F00, 1'b0);
		rd(orf_pkg::OFS_FP, 32'h0, 1'b0);
		// Completion on every base, error on odd bases
		for (int n = 0; n < 8; n++)
			xfer(1'b1, 1'b0, n[0], n[2:0], n[3:0]);
		for (int n = 0; n < 8; n++)
		begin
			rd(8'h40 + 8'(4 * n), n[0] ? 32'h1 << n : 32'h0, 1'b0);
			rd(8'h60 + 8'(4 * n), 32'h1 << n, 1'b0);
		end
		xfer(1'b0, 1'b1, 1'b0, 3'h3, 4'h3);
		rd(8'h6C, 32'h0, 1'b0);
		rd(8'h4C, 32'h0000_0008, 1'b0);
		// Unmapped and misaligned places are refused
		rd(8'h20, 32'h0, 1'b1);
		rd(8'h01, 32'h0, 1'b1);
		wr(8'h22, 32'h0000_0001, 1'b1);
		summarize();
	end
endmodule : tb
